// [pmeirq_top.v]
// Purpose: Interrupt enable and sticky status registers of a power-management
//          device, reached over AXI4-Lite, with one level interrupt output.
// Assumes: Event levels and pulses are synchronous to aclk.
// Notes:   A hardware set always wins over a clear in the same cycle.
`timescale 1ns/100ps
`include "pmeirq_defines.vh"

module pmeirq_top (
   // Clock and reset.
   input  wire                   aclk,
   input  wire                   aresetn,
   // AXI4-Lite write address and data.
   input  wire [`PMEIRQ_AW-1:0]  awaddr,
   input  wire [2:0]             awprot,
   input  wire                   awvalid,
   output reg                    awready,
   input  wire [`PMEIRQ_DW-1:0]  wdata,
   input  wire [3:0]             wstrb,
   input  wire                   wvalid,
   output reg                    wready,
   // AXI4-Lite write response.
   output reg  [1:0]             bresp,
   output reg                    bvalid,
   input  wire                   bready,
   // AXI4-Lite read.
   input  wire [`PMEIRQ_AW-1:0]  araddr,
   input  wire [2:0]             arprot,
   input  wire                   arvalid,
   output reg                    arready,
   output reg  [`PMEIRQ_DW-1:0]  rdata,
   output reg  [1:0]             rresp,
   output reg                    rvalid,
   input  wire                   rready,
   // Condition levels.
   input  wire                   vbus_over_voltage,
   input  wire                   vbus_present,
   input  wire                   battery_present,
   input  wire                   battery_safe_mode,
   input  wire                   charging,
   input  wire                   charge_overtemp,
   input  wire                   charge_undertemp,
   input  wire                   work_overtemp,
   input  wire                   work_undertemp,
   input  wire                   die_overtemp,
   input  wire                   capacity_below_one,
   input  wire                   capacity_below_two,
   // Event pulses, one cycle each.
   input  wire                   charge_done_pulse,
   input  wire                   adc_done_pulse,
   input  wire                   timer_timeout_pulse,
   input  wire                   key_rise_pulse,
   input  wire                   key_fall_pulse,
   input  wire                   key_short_press_pulse,
   input  wire                   key_long_press_pulse,
   input  wire                   key_off_press_pulse,
   input  wire                   gpio1_edge_pulse,
   input  wire                   gpio0_edge_pulse,
   input  wire                   charger_detect_change_pulse,
   input  wire                   id_multivalue_change_pulse,
   // Interrupt request, high level.
   output reg                    irq
);

   // Level history and edge detection.
   reg  [11:0]  lvl_q;
   reg          armed_q;
   wire [11:0]  lvl_now;
   wire [11:0]  rise;
   wire [11:0]  fall;

   // Registers.
   reg  [7:0]   en1_q;
   reg  [7:0]   en2_q;
   reg  [7:0]   en3_q;
   reg  [7:0]   en4_q;
   reg  [7:0]   en5_q;
   reg  [7:0]   en6_q;
   reg  [7:0]   st1_q;
   reg  [7:0]   st2_q;
   reg  [7:0]   st3_q;
   reg  [7:0]   st4_q;
   reg  [7:0]   st5_q;
   reg  [7:0]   st6_q;
   reg  [7:0]   st1_d;
   reg  [7:0]   st2_d;
   reg  [7:0]   st3_d;
   reg  [7:0]   st4_d;
   reg  [7:0]   st5_d;
   reg  [7:0]   st6_d;

   // Set vectors per status register; hardware-clear vectors for status registers 1 to 4 only.
   wire [7:0]   set1;
   wire [7:0]   set2;
   wire [7:0]   set3;
   wire [7:0]   set4;
   wire [7:0]   set5;
   wire [7:0]   set6;
   wire [7:0]   hcl1;
   wire [7:0]   hcl2;
   wire [7:0]   hcl3;
   wire [7:0]   hcl4;

   // Bus state.
   reg  [7:0]   aw_idx_q;
   reg          aw_full_q;
   reg  [7:0]   wd_q;
   reg          w_full_q;
   reg          w_lane_q;
   wire         aw_take;
   wire         w_take;
   wire         do_write;
   wire         ar_take;
   wire [7:0]   ar_idx;
   wire [7:0]   wbyte;
   reg  [7:0]   rd_byte;
   reg          rd_hit;
   reg          wr_hit;
   reg  [7:0]   w1c1;
   reg  [7:0]   w1c2;
   reg  [7:0]   w1c3;
   reg  [7:0]   w1c4;
   reg  [7:0]   w1c5;
   reg  [7:0]   w1c6;
   reg          aw_full_d;
   reg          w_full_d;
   reg          bvalid_d;
   reg          rvalid_d;

   // Levels: 11 ov, 10 vbus, 9 bat, 8 safe, 7 chg, 6 cot, 5 cut,
   // 4 wot, 3 wut, 2 die, 1 cap1, 0 cap2.
   assign lvl_now = {vbus_over_voltage, vbus_present, battery_present,
                     battery_safe_mode, charging, charge_overtemp,
                     charge_undertemp, work_overtemp, work_undertemp,
                     die_overtemp, capacity_below_one, capacity_below_two};

   // The first cycle after reset only captures the levels, so a condition
   // already present at release does not look like a fresh edge.
   assign rise = lvl_now & ~lvl_q & {12{armed_q}};
   assign fall = ~lvl_now & lvl_q & {12{armed_q}};

   always @(posedge aclk) begin
      if (!aresetn) begin
         lvl_q   <= 12'h000;
         armed_q <= 1'b0;
      end else begin
         lvl_q   <= lvl_now;
         armed_q <= 1'b1;
      end
   end

   // Supply input: bits 7:5 are independent copies of 4:2.
   assign set1 = {rise[11], rise[10], fall[10],
                  rise[11], rise[10], fall[10], 2'b00};
   assign hcl1 = {fall[11], fall[10], rise[10],
                  fall[11], fall[10], rise[10], 2'b00};

   // Battery presence, safe mode and charging.
   assign set2 = {rise[9], fall[9], rise[8], fall[8],
                  rise[7], charge_done_pulse, 2'b00};
   assign hcl2 = {fall[9], rise[9], fall[8], rise[8],
                  fall[7], rise[7], 2'b00};

   // Battery temperature: each flag and its exit flag clear one another.
   assign set3 = {rise[6], fall[6], rise[5], fall[5],
                  rise[4], fall[4], rise[3], fall[3]};
   assign hcl3 = {fall[6], rise[6], fall[5], rise[5],
                  fall[4], rise[4], fall[3], rise[3]};

   // Die temperature, conversion done and capacity warnings.
   assign set4 = {rise[2], 4'h0, adc_done_pulse, rise[1], rise[0]};
   assign hcl4 = {fall[2], 4'h0, 1'b0, fall[1], fall[0]};

   // Timer, key and gpio events only clear by software.
   assign set5 = {timer_timeout_pulse, key_rise_pulse, key_fall_pulse,
                  key_short_press_pulse, key_long_press_pulse,
                  key_off_press_pulse, gpio1_edge_pulse,
                  gpio0_edge_pulse};
   assign set6 = {6'h00, charger_detect_change_pulse,
                  id_multivalue_change_pulse};

   // Write and read channel handshakes.
   assign aw_take  = awvalid & awready;
   assign w_take   = wvalid & wready;
   assign do_write = aw_full_q & w_full_q;
   assign wbyte    = wd_q & {8{w_lane_q}};
   assign ar_take  = arvalid & arready;
   assign ar_idx   = araddr[9:2];

   // Write decode and write-one-to-clear strobes.
   always @* begin
      wr_hit = 1'b0;
      w1c1   = 8'h00;
      w1c2   = 8'h00;
      w1c3   = 8'h00;
      w1c4   = 8'h00;
      w1c5   = 8'h00;
      w1c6   = 8'h00;
      if (do_write) begin
         case (aw_idx_q)
            `PMEIRQ_IDX_EN1,
            `PMEIRQ_IDX_EN2,
            `PMEIRQ_IDX_EN3,
            `PMEIRQ_IDX_EN4,
            `PMEIRQ_IDX_EN5,
            `PMEIRQ_IDX_EN6: wr_hit = 1'b1;
            `PMEIRQ_IDX_ST1: begin
               wr_hit = 1'b1;
               w1c1   = wbyte;
            end
            `PMEIRQ_IDX_ST2: begin
               wr_hit = 1'b1;
               w1c2   = wbyte;
            end
            `PMEIRQ_IDX_ST3: begin
               wr_hit = 1'b1;
               w1c3   = wbyte;
            end
            `PMEIRQ_IDX_ST4: begin
               wr_hit = 1'b1;
               w1c4   = wbyte;
            end
            `PMEIRQ_IDX_ST5: begin
               wr_hit = 1'b1;
               w1c5   = wbyte;
            end
            `PMEIRQ_IDX_ST6: begin
               wr_hit = 1'b1;
               w1c6   = wbyte;
            end
            default: wr_hit = 1'b0;
         endcase
      end
   end

   // Sticky flags: a set in the same cycle as any clear wins.
   always @* begin
      st1_d = set1 | (st1_q & ~(w1c1 | hcl1));
      st2_d = set2 | (st2_q & ~(w1c2 | hcl2));
      st3_d = set3 | (st3_q & ~(w1c3 | hcl3));
      st4_d = set4 | (st4_q & ~(w1c4 | hcl4));
      st5_d = set5 | (st5_q & ~w1c5);
      st6_d = set6 | (st6_q & ~w1c6);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         st1_q <= `PMEIRQ_RST_ST;
         st2_q <= `PMEIRQ_RST_ST;
         st3_q <= `PMEIRQ_RST_ST;
         st4_q <= `PMEIRQ_RST_ST;
         st5_q <= `PMEIRQ_RST_ST;
         st6_q <= `PMEIRQ_RST_ST;
      end else begin
         st1_q <= st1_d;
         st2_q <= st2_d;
         st3_q <= st3_d;
         st4_q <= st4_d;
         st5_q <= st5_d;
         st6_q <= st6_d;
      end
   end

   // Enable registers; reserved bits are held at zero by the masks.
   always @(posedge aclk) begin
      if (!aresetn) begin
         en1_q <= `PMEIRQ_RST_EN1;
         en2_q <= `PMEIRQ_RST_EN2;
         en3_q <= `PMEIRQ_RST_EN3;
         en4_q <= `PMEIRQ_RST_EN4;
         en5_q <= `PMEIRQ_RST_EN5;
         en6_q <= `PMEIRQ_RST_EN6;
      end else if (do_write && w_lane_q) begin
         case (aw_idx_q)
            `PMEIRQ_IDX_EN1: en1_q <= wd_q & `PMEIRQ_MSK_EN1;
            `PMEIRQ_IDX_EN2: en2_q <= wd_q & `PMEIRQ_MSK_EN2;
            `PMEIRQ_IDX_EN3: en3_q <= wd_q & `PMEIRQ_MSK_EN3;
            `PMEIRQ_IDX_EN4: en4_q <= wd_q & `PMEIRQ_MSK_EN4;
            `PMEIRQ_IDX_EN5: en5_q <= wd_q & `PMEIRQ_MSK_EN5;
            `PMEIRQ_IDX_EN6: en6_q <= wd_q & `PMEIRQ_MSK_EN6;
            default: en1_q <= en1_q;
         endcase
      end
   end

   // Interrupt follows the next flag state, so it rises with the flag.
   always @(posedge aclk) begin
      if (!aresetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((st1_d & en1_q) | (st2_d & en2_q) | (st3_d & en3_q) |
                  (st4_d & en4_q) | (st5_d & en5_q) | (st6_d & en6_q));
      end
   end

   // Write path: address and data are held independently, in either order,
   // and the response follows one cycle after both are present.
   always @* begin
      aw_full_d = (aw_full_q | aw_take) & ~do_write;
      w_full_d  = (w_full_q | w_take) & ~do_write;
      bvalid_d  = do_write | (bvalid & ~bready);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         aw_idx_q  <= 8'h00;
         wd_q      <= 8'h00;
         w_lane_q  <= 1'b0;
         awready   <= 1'b0;
         wready    <= 1'b0;
         bvalid    <= 1'b0;
         bresp     <= `PMEIRQ_RESP_OKAY;
      end else begin
         aw_full_q <= aw_full_d;
         w_full_q  <= w_full_d;
         if (aw_take) begin
            aw_idx_q <= awaddr[9:2];
         end
         if (w_take) begin
            wd_q     <= wdata[7:0];
            w_lane_q <= wstrb[0];
         end
         awready <= ~aw_full_d & ~bvalid_d;
         wready  <= ~w_full_d & ~bvalid_d;
         bvalid  <= bvalid_d;
         if (do_write) begin
            bresp <= wr_hit ? `PMEIRQ_RESP_OKAY : `PMEIRQ_RESP_SLVERR;
         end
      end
   end

   // Read decode; reads have no side effect on the flags.
   always @* begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (ar_idx)
         `PMEIRQ_IDX_EN1: rd_byte = en1_q;
         `PMEIRQ_IDX_EN2: rd_byte = en2_q;
         `PMEIRQ_IDX_EN3: rd_byte = en3_q;
         `PMEIRQ_IDX_EN4: rd_byte = en4_q;
         `PMEIRQ_IDX_EN5: rd_byte = en5_q;
         `PMEIRQ_IDX_EN6: rd_byte = en6_q;
         `PMEIRQ_IDX_ST1: rd_byte = st1_q;
         `PMEIRQ_IDX_ST2: rd_byte = st2_q;
         `PMEIRQ_IDX_ST3: rd_byte = st3_q;
         `PMEIRQ_IDX_ST4: rd_byte = st4_q;
         `PMEIRQ_IDX_ST5: rd_byte = st5_q;
         `PMEIRQ_IDX_ST6: rd_byte = st6_q;
         default:         rd_hit  = 1'b0;
      endcase
   end

   always @* begin
      rvalid_d = ar_take | (rvalid & ~rready);
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         arready <= 1'b0;
         rvalid  <= 1'b0;
         rdata   <= 32'h0000_0000;
         rresp   <= `PMEIRQ_RESP_OKAY;
      end else begin
         arready <= ~rvalid_d;
         rvalid  <= rvalid_d;
         if (ar_take) begin
            rdata <= {24'h000000, rd_byte};
            rresp <= rd_hit ? `PMEIRQ_RESP_OKAY : `PMEIRQ_RESP_SLVERR;
         end
      end
   end

endmodule // pmeirq_top

// [pmeirq_defines.vh]
// Purpose: Constants for the power-management event interrupt block.
// Assumes: AXI4-Lite byte address is four times the register index.
// Notes:   Enable masks keep reserved bits reading as zero.
`ifndef PMEIRQ_DEFINES_VH
`define PMEIRQ_DEFINES_VH

`define PMEIRQ_AW          12
`define PMEIRQ_DW          32

// Register indices.
`define PMEIRQ_IDX_EN1     8'h40
`define PMEIRQ_IDX_EN2     8'h41
`define PMEIRQ_IDX_EN3     8'h42
`define PMEIRQ_IDX_EN4     8'h43
`define PMEIRQ_IDX_EN5     8'h44
`define PMEIRQ_IDX_EN6     8'h45
`define PMEIRQ_IDX_ST1     8'h48
`define PMEIRQ_IDX_ST2     8'h49
`define PMEIRQ_IDX_ST3     8'h4a
`define PMEIRQ_IDX_ST4     8'h4b
`define PMEIRQ_IDX_ST5     8'h4c
`define PMEIRQ_IDX_ST6     8'h4d

// Enable and status reset values.
`define PMEIRQ_RST_EN1     8'hd8
`define PMEIRQ_RST_EN2     8'hff
`define PMEIRQ_RST_EN3     8'hff
`define PMEIRQ_RST_EN4     8'h03
`define PMEIRQ_RST_EN5     8'h7c
`define PMEIRQ_RST_EN6     8'h00
`define PMEIRQ_RST_ST      8'h00

// Writable bits of each enable register.
`define PMEIRQ_MSK_EN1     8'hfc
`define PMEIRQ_MSK_EN2     8'hff
`define PMEIRQ_MSK_EN3     8'hff
`define PMEIRQ_MSK_EN4     8'h87
`define PMEIRQ_MSK_EN5     8'hff
`define PMEIRQ_MSK_EN6     8'h03

// AXI responses.
`define PMEIRQ_RESP_OKAY   2'b00
`define PMEIRQ_RESP_SLVERR 2'b10

`endif

// [pmeirq_checker.sv]
// Purpose: Bus and interrupt checks on the event interrupt register block.
// Assumes: One clock domain; the checker sees only the top module's ports.
// Notes:   Every interrupt edge must trace back to an event or a bus write.
`timescale 1ns/100ps
`include "pmeirq_defines.vh"
module pmeirq_checker (
   // Clock, reset and handshakes.
   input wire        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready,
   input wire        arvalid, arready, rvalid, rready, irq,
   // Response and read data.
   input wire [1:0]  bresp, rresp,
   input wire [31:0] rdata,
   // Condition levels.
   input wire        vbus_over_voltage, vbus_present, battery_present, battery_safe_mode,
   input wire        charging, charge_overtemp, charge_undertemp, work_overtemp,
   input wire        work_undertemp, die_overtemp, capacity_below_one, capacity_below_two,
   // Event pulses.
   input wire        charge_done_pulse, adc_done_pulse, timer_timeout_pulse, key_rise_pulse,
   input wire        key_fall_pulse, key_short_press_pulse, key_long_press_pulse,
   input wire        key_off_press_pulse, gpio1_edge_pulse, gpio0_edge_pulse,
   input wire        charger_detect_change_pulse, id_multivalue_change_pulse
);
   wire [11:0] lv = {vbus_over_voltage, vbus_present, battery_present, battery_safe_mode,
      charging, charge_overtemp, charge_undertemp, work_overtemp, work_undertemp,
      die_overtemp, capacity_below_one, capacity_below_two};
   wire [11:0] pv = {charge_done_pulse, adc_done_pulse, timer_timeout_pulse, key_rise_pulse,
      key_fall_pulse, key_short_press_pulse, key_long_press_pulse, key_off_press_pulse,
      gpio1_edge_pulse, gpio0_edge_pulse, charger_detect_change_pulse,
      id_multivalue_change_pulse};
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   sequence s_write_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_read_taken;
      arvalid && arready;
   endsequence
   a_write_answer: assert property (s_write_taken |-> ##2 bvalid)
      else $error("write response late");
   a_read_answer: assert property (s_read_taken |=> rvalid)
      else $error("read response late");
   a_resp_hold: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
      else $error("write response dropped");
   a_read_hold: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data dropped");
   a_write_refused: assert property (bvalid |-> !awready && !wready)
      else $error("write accepted while answer pending");
   a_read_refused: assert property (rvalid |-> !arready)
      else $error("read accepted while answer pending");
   a_error_data: assert property (rvalid && rresp == `PMEIRQ_RESP_SLVERR |-> rdata == 32'h0)
      else $error("error read returned data");
   a_irq_reset_low: assert property ($rose(aresetn) |-> !irq)
      else $error("interrupt high after reset");
   // Enable writes move the interrupt one cycle after the write response is raised.
   a_irq_rise_cause: assert property ($rose(irq) |-> $past(|pv) ||
      $past(lv) != $past(lv, 2) || $past(bvalid)) else $error("interrupt rose without cause");
   a_irq_fall_cause: assert property ($fell(irq) |-> $past(lv) != $past(lv, 2) ||
      bvalid || $past(bvalid)) else $error("interrupt fell without cause");
endmodule // pmeirq_checker

bind pmeirq_top pmeirq_checker u_chk (.*);

// [pmeirq_host.sv]
// Purpose: AXI4-Lite host that services the event interrupt registers.
// Assumes: The bench calls one transfer at a time.
// Notes:   Waits are open here; the bench timeout cuts a hang short.
`timescale 1ns/100ps
module pmeirq_host (
   // Clock.
   input  wire        aclk,
   // Master side.
   output reg  [11:0] awaddr, araddr,
   output reg  [31:0] wdata,
   output reg  [3:0]  wstrb,
   output reg  [2:0]  awprot, arprot,
   output reg         awvalid, wvalid, bready, arvalid, rready,
   // Slave side.
   input  wire        awready, wready, bvalid, arready, rvalid,
   input  wire [1:0]  bresp, rresp,
   input  wire [31:0] rdata
);
   reg       done;
   reg [3:0] strb;
   integer   n;
   initial begin
      {awaddr, araddr, wdata, wstrb, awprot, arprot} = 66'h0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      strb = 4'h1;
   end
   // A clearing write carries ones only in the bits being serviced.
   task wr(input [11:0] a, input [7:0] d, output [1:0] r);
      begin
         @(posedge aclk);
         awaddr <= a;
         wdata <= {24'h0, d};
         wstrb <= strb;
         awvalid <= 1'b1;
         wvalid <= 1'b1;
         // A late bready makes the slave hold its answer for a few cycles.
         n = $urandom % 4;
         done = 1'b0;
         while (!done) begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
               r = bresp;
               bready <= 1'b0;
               done = 1'b1;
            end else if (n == 0) begin
               bready <= 1'b1;
            end else begin
               n = n - 1;
            end
         end
      end
   endtask
   task rd(input [11:0] a, output [31:0] d, output [1:0] r);
      begin
         @(posedge aclk);
         araddr <= a;
         arvalid <= 1'b1;
         // A late rready makes the slave hold its read data for a few cycles.
         n = $urandom % 4;
         done = 1'b0;
         while (!done) begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
               d = rdata;
               r = rresp;
               rready <= 1'b0;
               done = 1'b1;
            end else if (n == 0) begin
               rready <= 1'b1;
            end else begin
               n = n - 1;
            end
         end
      end
   endtask
endmodule // pmeirq_host

// [tb.sv]
// Purpose: Self-checking bench for the event interrupt register block.
// Assumes: Levels and pulses change one event at a time.
// Notes:   A byte model of every register predicts reads and the interrupt.
`timescale 1ns/100ps
`include "pmeirq_defines.vh"
`define CHK(nm, e, s) begin num_checks = num_checks + 1; if ((e) !== (s)) begin \
   n_fail = n_fail + 1; $display("unexpected %s expected %0h seen %0h", nm, e, s); end end
module tb;
   reg         aclk, aresetn;
   reg  [11:0] lv, pv;
   wire [11:0] awaddr, araddr;
   wire [31:0] wdata, rdata;
   wire [3:0]  wstrb;
   wire [2:0]  awprot, arprot;
   wire [1:0]  bresp, rresp;
   wire        awvalid, awready, wvalid, wready, bvalid, bready;
   wire        arvalid, arready, rvalid, rready, irq;
   integer     n_fail, num_checks, cyc, i, k, b;
   reg  [7:0]  m [0:11];
   reg  [31:0] d;
   reg  [1:0]  r;
   // Level table: status index, bits set on rise, bits set on fall, fall sets.
   reg  [31:0] lt [0:11] = '{32'h06900000, 32'h06482401, 32'h07804001, 32'h07201001,
      32'h07080400, 32'h08804001, 32'h08201001, 32'h08080401, 32'h08020101,
      32'h09800000, 32'h09020000, 32'h09010000};
   reg  [15:0] pt [0:11] = '{16'h0704, 16'h0904, 16'h0a80, 16'h0a40, 16'h0a20, 16'h0a10,
      16'h0a08, 16'h0a04, 16'h0a02, 16'h0a01, 16'h0b02, 16'h0b01};
   reg  [7:0]  msk [0:5] = '{`PMEIRQ_MSK_EN1, `PMEIRQ_MSK_EN2, `PMEIRQ_MSK_EN3,
      `PMEIRQ_MSK_EN4, `PMEIRQ_MSK_EN5, `PMEIRQ_MSK_EN6};
   reg  [7:0]  rv [0:5] = '{`PMEIRQ_RST_EN1, `PMEIRQ_RST_EN2, `PMEIRQ_RST_EN3,
      `PMEIRQ_RST_EN4, `PMEIRQ_RST_EN5, `PMEIRQ_RST_EN6};
   pmeirq_top dut (.*, .vbus_over_voltage(lv[0]), .vbus_present(lv[1]),
      .battery_present(lv[2]), .battery_safe_mode(lv[3]), .charging(lv[4]),
      .charge_overtemp(lv[5]), .charge_undertemp(lv[6]), .work_overtemp(lv[7]),
      .work_undertemp(lv[8]), .die_overtemp(lv[9]), .capacity_below_one(lv[10]),
      .capacity_below_two(lv[11]), .charge_done_pulse(pv[0]), .adc_done_pulse(pv[1]),
      .timer_timeout_pulse(pv[2]), .key_rise_pulse(pv[3]), .key_fall_pulse(pv[4]),
      .key_short_press_pulse(pv[5]), .key_long_press_pulse(pv[6]),
      .key_off_press_pulse(pv[7]), .gpio1_edge_pulse(pv[8]), .gpio0_edge_pulse(pv[9]),
      .charger_detect_change_pulse(pv[10]), .id_multivalue_change_pulse(pv[11]));
   pmeirq_host host (.*);
   always #50 aclk = ~aclk;
   always @(posedge aclk) begin
      cyc = cyc + 1;
      if (cyc == 20000) begin
         n_fail = n_fail + 1;
         end_sim;
      end
   end
   function [11:0] adr(input integer x);
      adr = (x < 6) ? 12'h100 + 4 * x : 12'h108 + 4 * x;
   endfunction
   task end_sim;
      begin
         $display("checks %0d mismatches %0d", num_checks, n_fail);
         if (n_fail == 0 && num_checks > 0)
            $display("All checks passed");
         else
            $display("Checks failed");
         $finish;
      end
   endtask
   task chk_reg(input integer x);
      begin
         host.rd(adr(x), d, r);
         `CHK("rdata", {24'h0, m[x]}, d)
         `CHK("rresp", `PMEIRQ_RESP_OKAY, r)
      end
   endtask
   task chk_irq;
      integer j;
      reg     e;
      begin
         @(posedge aclk);
         e = 1'b0;
         for (j = 0; j < 6; j++) e = e | (|(m[j] & m[j + 6]));
         `CHK("irq", e, irq)
      end
   endtask
   task lvl(input integer x, input v);
      reg [31:0] e;
      begin
         e = lt[x];
         @(posedge aclk);
         lv[x] <= v;
         if (v) m[e[31:24]] = (m[e[31:24]] & ~e[15:8]) | e[23:16];
         else m[e[31:24]] = (m[e[31:24]] & ~e[23:16]) | (e[0] ? e[15:8] : 8'h0);
         @(posedge aclk);
         chk_irq;
         chk_reg(e[31:24]);
      end
   endtask
   task pul(input integer x);
      begin
         @(posedge aclk);
         pv[x] <= 1'b1;
         @(posedge aclk);
         pv[x] <= 1'b0;
         m[pt[x][15:8]] = m[pt[x][15:8]] | pt[x][7:0];
         chk_irq;
         chk_reg(pt[x][15:8]);
      end
   endtask
   initial begin
      {aclk, aresetn, lv, pv} = 26'h0;
      {n_fail, num_checks, cyc} = 96'h0;
      i = $urandom(32'h4f86);
      for (i = 0; i < 6; i++) {m[i], m[i + 6]} = {rv[i], 8'h0};
      repeat (5) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 12; i++) chk_reg(i);
      chk_irq;
      host.rd(12'h140, d, r);
      `CHK("unmapped rresp", `PMEIRQ_RESP_SLVERR, r)
      host.wr(12'h140, 8'hff, r);
      `CHK("unmapped bresp", `PMEIRQ_RESP_SLVERR, r)
      for (i = 0; i < 6; i++) begin
         d = $urandom;
         host.wr(adr(i), d[7:0], r);
         m[i] = d[7:0] & msk[i];
         `CHK("bresp", `PMEIRQ_RESP_OKAY, r)
         chk_reg(i);
         host.wr(adr(i), 8'hff, r);
         m[i] = msk[i];
      end
      // A write with its byte lane off changes nothing, yet is still answered OKAY.
      host.strb = 4'h0;
      host.wr(adr(0), 8'h00, r);
      host.strb = 4'h1;
      `CHK("lane off bresp", `PMEIRQ_RESP_OKAY, r)
      chk_reg(0);
      for (k = 0; k < 12; k++) begin
         lvl(k, 1'b1);
         lvl(k, 1'b0);
      end
      for (k = 0; k < 12; k++) pul(k);
      lvl(4, 1'b1);
      for (i = 0; i < 6; i++) begin
         d = $urandom;
         host.wr(adr(i), d[7:0], r);
         m[i] = d[7:0] & msk[i];
         chk_irq;
      end
      // One bit at a time, so a clear that spills onto its neighbours shows up.
      for (i = 6; i < 12; i++)
         for (b = 7; b >= 0; b--)
            if (m[i][b]) begin
               host.wr(adr(i), 8'h1 << b, r);
               m[i][b] = 1'b0;
               chk_reg(i);
               chk_irq;
            end
      // A second reset mid-run: enables return to defaults, flags drop, and a
      // level that is still high at release must not look like a fresh edge.
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      for (i = 0; i < 6; i++) {m[i], m[i + 6]} = {rv[i], 8'h0};
      for (i = 0; i < 12; i++) chk_reg(i);
      chk_irq;
      end_sim;
   end
endmodule // tb
